// ===== design/rx_fifo_reset_pkg.sv
// Constants shared by the receive FIFO reset controller
// Operation
// - Violation output driven only while output enabled
// - FIFO reset input active low, sampled each clock
// - Start reset after seven qualified low samples
// - On start, assert empty, zero counters, pointers
// - Reset clears write pointers and write counters
// - Empty stays asserted until next character written
// - While reset held low, refuse received characters
// - FIFO bypassed: ignore the FIFO reset input
`default_nettype none

package rx_fifo_reset_pkg;

    // ********************************************************
    // Bus layout
    // ********************************************************
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET = 8'h04;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int          CTRL_ACCEPT_BIT  = 0;
    localparam logic        CTRL_ACCEPT_RST  = 1'h1;
    localparam int          STAT_EMPTY_BIT   = 0;
    localparam int          STAT_RESET_BIT   = 1;
    localparam int          STAT_FULL_BIT    = 2;
    localparam int          STAT_COUNT_LSB   = 8;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int          RESET_LOW_CYCLES = 7;
    localparam logic [2:0]  LOW_CNT_LAST     = 3'h6;

endpackage : rx_fifo_reset_pkg

`default_nettype wire

// ===== design/rx_fifo_reset_control.sv
// Receive FIFO with qualified reset sequencing and register slave
`default_nettype none

module rx_fifo_reset_control #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                               clock,
    input  wire logic                               resetn,
    // AXI4-Lite slave
    input  wire logic [rx_fifo_reset_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                               awvalid,
    output logic                                    awready,
    input  wire logic [31:0]                        wdata,
    input  wire logic [3:0]                         wstrb,
    input  wire logic                               wvalid,
    output logic                                    wready,
    output logic [1:0]                              bresp,
    output logic                                    bvalid,
    input  wire logic                               bready,
    input  wire logic [rx_fifo_reset_pkg::ADDR_W-1:0] araddr,
    input  wire logic                               arvalid,
    output logic                                    arready,
    output logic [31:0]                             rdata,
    output logic [1:0]                              rresp,
    output logic                                    rvalid,
    input  wire logic                               rready,
    // Receive port pins
    input  wire logic                               rx_fifo_reset_n,
    input  wire logic                               rx_output_enable,
    input  wire logic                               chip_enable_n,
    input  wire logic                               fifo_bypass_n,
    input  wire logic                               char_valid,
    input  wire logic [WIDTH-1:0]                   char_data,
    input  wire logic                               code_violation_in,
    input  wire logic                               rx_read,
    output logic [WIDTH-1:0]                        rx_data,
    output logic                                    rx_data_valid,
    output logic                                    rx_fifo_empty_flag,
    output logic                                    code_violation_flag,
    output logic                                    code_violation_oe
);

    localparam int AW = $clog2(DEPTH);

    // Refuse sizes the pointer and status logic cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0
        || DEPTH > 128) begin : g_bad_depth
        $error("DEPTH must be a power of two from 2 to 128");
    end
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("WIDTH must be 1 to 32");
    end

    function automatic logic hit(
        input logic [rx_fifo_reset_pkg::ADDR_W-1:0] addr,
        input logic [7:0]                           offs
    );
        hit = (addr[rx_fifo_reset_pkg::ADDR_W-1:2] == offs[7:2]);
    endfunction : hit

    // ********************************************************
    // Reset release
    // ********************************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    // Two stages so release is clean against the clock
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ********************************************************
    // FIFO reset sequencing
    // ********************************************************
    logic [2:0]    low_cnt_reg;
    logic          in_reset_reg;
    logic          in_reset_next;
    logic          start_cond;
    logic          start_pulse;
    logic          accept_reg;

    // Low sample only counts with all side conditions met
    assign start_cond = !rx_fifo_reset_n && fifo_bypass_n
                        && !rx_output_enable && !chip_enable_n;
    assign start_pulse = !in_reset_reg && start_cond
                         && low_cnt_reg == rx_fifo_reset_pkg::LOW_CNT_LAST;

    // Bypass wins over everything; held reset outlives qualifiers
    always_comb begin
        if (!fifo_bypass_n) begin
            in_reset_next = 1'b0;
        end else if (in_reset_reg) begin
            in_reset_next = !rx_fifo_reset_n;
        end else begin
            in_reset_next = start_pulse;
        end
    end

    // Counter restarts on any break in the qualifying run
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg  <= 3'h0;
            in_reset_reg <= 1'b0;
        end else begin
            in_reset_reg <= in_reset_next;
            if (start_cond && !in_reset_reg && !start_pulse) begin
                low_cnt_reg <= low_cnt_reg + 3'h1;
            end else begin
                low_cnt_reg <= 3'h0;
            end
        end
    end

    // ********************************************************
    // FIFO storage
    // ********************************************************
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             full;
    logic             wr_en;
    logic             rd_en;

    assign full  = (count_reg == DEPTH[AW:0]);
    // Nothing stored in the cycle a reset starts or holds
    assign wr_en = char_valid && !in_reset_next && accept_reg
                   && !full;
    assign rd_en = rx_read && !rx_fifo_empty_flag && !in_reset_next;

    always_comb begin
        if (in_reset_next) begin
            count_next = '0;
        end else begin
            count_next = count_reg + {{AW{1'b0}}, wr_en}
                         - {{AW{1'b0}}, rd_en};
        end
    end

    // Data words need no reset; pointers guard them
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_reg[wr_ptr_reg] <= char_data;
        end
    end

    // Pointers, count and empty flag move together
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg         <= '0;
            rd_ptr_reg         <= '0;
            count_reg          <= '0;
            rx_fifo_empty_flag <= 1'b1;
        end else begin
            count_reg          <= count_next;
            rx_fifo_empty_flag <= (count_next == '0);
            if (in_reset_next) begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
            end else begin
                if (wr_en) wr_ptr_reg <= wr_ptr_reg + 1'b1;
                if (rd_en) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    // Read port: one word per strobe, valid one cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_data       <= '0;
            rx_data_valid <= 1'b0;
        end else begin
            rx_data_valid <= rd_en;
            if (rd_en) rx_data <= mem_reg[rd_ptr_reg];
        end
    end

    // ********************************************************
    // Code violation output
    // ********************************************************
    // Flag forced low when undriven so the bench sees no stale level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            code_violation_flag <= 1'b0;
            code_violation_oe   <= 1'b0;
        end else begin
            code_violation_oe   <= rx_output_enable;
            code_violation_flag <= rx_output_enable && code_violation_in;
        end
    end

    // ********************************************************
    // AXI4-Lite slave
    // ********************************************************
    logic                              aw_held_reg;
    logic                              w_held_reg;
    logic [rx_fifo_reset_pkg::ADDR_W-1:0] aw_addr_reg;
    logic [31:0]                       w_data_reg;
    logic [3:0]                        w_strb_reg;
    logic [31:0]                       status;

    assign status = {{(23 - AW){1'b0}}, count_reg, 5'h0, full,
                     in_reset_reg, rx_fifo_empty_flag};

    // Address and data taken in either order; answer after both
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            awready     <= 1'b1;
            wready      <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid      <= 1'b0;
            bresp       <= rx_fifo_reset_pkg::RESP_OKAY;
            accept_reg  <= rx_fifo_reset_pkg::CTRL_ACCEPT_RST;
        end else begin
            if (awvalid && awready) begin
                awready     <= 1'b0;
                aw_held_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wready     <= 1'b0;
                w_held_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (aw_held_reg && w_held_reg && !bvalid) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid      <= 1'b1;
                if (hit(aw_addr_reg, rx_fifo_reset_pkg::CTRL_OFFSET)) begin
                    bresp <= rx_fifo_reset_pkg::RESP_OKAY;
                    if (w_strb_reg[0])
                        accept_reg <= w_data_reg[
                            rx_fifo_reset_pkg::CTRL_ACCEPT_BIT];
                end else if (hit(aw_addr_reg,
                                 rx_fifo_reset_pkg::STATUS_OFFSET)) begin
                    bresp <= rx_fifo_reset_pkg::RESP_OKAY;
                end else begin
                    bresp <= rx_fifo_reset_pkg::RESP_SLVERR;
                end
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Reads answer one cycle after the address is taken
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= rx_fifo_reset_pkg::RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= rx_fifo_reset_pkg::RESP_OKAY;
                if (hit(araddr, rx_fifo_reset_pkg::CTRL_OFFSET)) begin
                    rdata <= {31'h0000_0000, accept_reg};
                end else if (hit(araddr,
                                 rx_fifo_reset_pkg::STATUS_OFFSET)) begin
                    rdata <= status;
                end else begin
                    rdata <= 32'h0000_0000;
                    rresp <= rx_fifo_reset_pkg::RESP_SLVERR;
                end
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_start_after_seven: assert property (
        (start_cond && !in_reset_reg)[*7] |=> in_reset_reg)
        else $error("reset did not start after seven low samples");
    a_no_early_start: assert property (
        $rose(in_reset_reg) |-> $past(start_cond)
            && $past(low_cnt_reg) == rx_fifo_reset_pkg::LOW_CNT_LAST)
        else $error("reset started without seven qualified samples");
    a_empty_on_start: assert property (
        $rose(in_reset_reg) |-> rx_fifo_empty_flag && count_reg == '0
            && rd_ptr_reg == '0)
        else $error("start did not empty the FIFO at once");
    a_ptrs_held_clear: assert property (
        in_reset_reg |-> wr_ptr_reg == '0 && count_reg == '0)
        else $error("write side not cleared during reset");
    a_empty_until_write: assert property (
        rx_fifo_empty_flag && !wr_en |=> rx_fifo_empty_flag)
        else $error("empty flag fell without a write");
    a_no_store_reset: assert property (
        in_reset_reg && !rx_fifo_reset_n && fifo_bypass_n
            |=> wr_ptr_reg == '0 && count_reg == '0 && rx_fifo_empty_flag)
        else $error("character stored while reset held");
    a_bypass_ignores: assert property (
        !fifo_bypass_n |=> !in_reset_reg && low_cnt_reg == 3'h0)
        else $error("reset input acted while FIFO bypassed");
    a_resume_release: assert property (
        in_reset_reg && rx_fifo_reset_n |=> !in_reset_reg)
        else $error("reset not left after input released");
    a_violation_driven: assert property (
        code_violation_flag |-> code_violation_oe
            && $past(code_violation_in))
        else $error("violation flag high while not driven");

    c_reset_start: cover property ($rose(in_reset_reg));
    c_reset_release: cover property ($fell(in_reset_reg) ##[1:20] wr_en);
    c_fifo_full: cover property (full);
    c_bus_read: cover property (rvalid && rready);

endmodule : rx_fifo_reset_control

`default_nettype wire

// ===== tb/host_reader.sv
// Host-side reader model for the receive port
`default_nettype none

module host_reader (
    input  wire logic clock,
    input  wire logic go,
    input  wire logic slow,
    input  wire logic rx_fifo_empty_flag,
    output var logic  rx_read
);
    timeunit 1ns;
    timeprecision 1ns;

    logic skip_reg;

    initial begin
        rx_read  = 1'b0;
        skip_reg = 1'b0;
    end

    // Pull words while non-empty; slow mode stalls every other cycle
    always @(posedge clock) begin
        skip_reg <= slow & ~skip_reg;
        rx_read  <= go & ~rx_fifo_empty_flag & ~(slow & ~skip_reg);
    end

endmodule : host_reader

`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the receive FIFO reset controller
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int DEPTH = 16;
    localparam logic [7:0] STAT = rx_fifo_reset_pkg::STATUS_OFFSET;
    localparam logic [7:0] CTRL = rx_fifo_reset_pkg::CTRL_OFFSET;

    logic clock, resetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr, char_data;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic rx_fifo_reset_n, rx_output_enable, chip_enable_n, fifo_bypass_n;
    logic char_valid, code_violation_in, rx_read, go, slow;
    logic awready, wready, bvalid, arready, rvalid, rx_data_valid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] rx_data;
    logic rx_fifo_empty_flag, code_violation_flag, code_violation_oe;
    int n_fail, checked, seed;
    logic [7:0] exp_q[$], got[$];
    logic [31:0] d;
    logic [1:0] r;

    rx_fifo_reset_control #(.WIDTH(8), .DEPTH(DEPTH)) dut (
        .clock, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .rx_fifo_reset_n,
        .rx_output_enable, .chip_enable_n, .fifo_bypass_n, .char_valid,
        .char_data, .code_violation_in, .rx_read, .rx_data,
        .rx_data_valid, .rx_fifo_empty_flag, .code_violation_flag,
        .code_violation_oe);

    host_reader host (.clock, .go, .slow, .rx_fifo_empty_flag, .rx_read);

    // ********************
    // Clock, capture, watchdog
    // ********************
    always #5 clock = ~clock;

    // Collect every word the port hands out
    always @(posedge clock) begin
        if (rx_data_valid === 1'b1) begin
            got.push_back(rx_data);
        end
    end

    // Whole run is a few hundred cycles; this limit is 20000 cycles
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end

    // ********************
    // Tasks
    // ********************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] exp_stat(input int cnt, input logic inr);
        exp_stat = 32'(cnt) << 8;
        exp_stat[0] = (cnt == 0);
        exp_stat[1] = inr;
        exp_stat[2] = (cnt == DEPTH);
    endfunction : exp_stat

    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            k++;
        end while (bvalid !== 1'b1 && k < 100);
        r = bresp;
        if (k >= 100) n_fail++;
    endtask : axi_wr

    task axi_rd(input logic [7:0] a);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            k++;
        end while (rvalid !== 1'b1 && k < 100);
        d = rdata;
        r = rresp;
        if (k >= 100) n_fail++;
    endtask : axi_rd

    // Back-to-back characters, one per edge
    task push(input int n, input bit keep);
        logic [7:0] v;
        for (int i = 0; i < n; i++) begin
            v = 8'($random(seed));
            char_data <= v;
            char_valid <= 1'b1;
            if (keep) exp_q.push_back(v);
            @(posedge clock);
        end
        char_valid <= 1'b0;
    endtask : push

    task stat_is(input int cnt, input logic inr);
        axi_rd(STAT);
        check(d, exp_stat(cnt, inr));
    endtask : stat_is

    task hold_reset(input int n);
        rx_fifo_reset_n <= 1'b0;
        repeat (n) @(posedge clock);
        rx_fifo_reset_n <= 1'b1;
    endtask : hold_reset

    task drain;
        int k;
        go <= 1'b1;
        slow <= 1'($random(seed));
        k = 0;
        while (got.size() < exp_q.size() && k < 200) begin
            @(posedge clock);
            k++;
        end
        go <= 1'b0;
        repeat (3) @(posedge clock);
        check(32'(got.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) check(32'(got[i]), 32'(exp_q[i]));
        got.delete();
        exp_q.delete();
    endtask : drain

    task finish_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // ********************
    // Main sequence
    // ********************
    initial begin
        seed = 99;
        {clock, resetn, awvalid, wvalid, arvalid, char_valid, go, slow} = '0;
        {awaddr, araddr, char_data, wdata, code_violation_in} = '0;
        {rx_output_enable, chip_enable_n} = '0;
        {bready, rready, rx_fifo_reset_n, fifo_bypass_n} = '1;
        wstrb = 4'hF;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        axi_rd(CTRL);
        check(d, 32'h1);
        check(32'(r), 32'h0);
        stat_is(0, 1'b0);
        axi_rd(8'h08);
        check(d, 32'h0);
        check(32'(r), 32'h2);
        axi_wr(8'h0C, 32'h0);
        check(32'(r), 32'h2);
        $display("test registers done");
        push(($random(seed) & 3) + 3, 1'b1);
        stat_is(exp_q.size(), 1'b0);
        drain();
        $display("test fill and drain done");
        // The first three passes each break one qualifier, the last is one sample short
        push(2, 1'b1);
        for (int q = 0; q < 4; q++) begin
            rx_output_enable <= (q == 0);
            chip_enable_n <= (q == 1);
            fifo_bypass_n <= (q != 2);
            hold_reset(q == 3 ? 6 : 7);
            {rx_output_enable, chip_enable_n, fifo_bypass_n} <= 3'h1;
            stat_is(2, 1'b0);
        end
        hold_reset(7);
        exp_q.delete();
        // Read is taken on the edge that leaves reset, so still in reset
        stat_is(0, 1'b1);
        drain();
        $display("test reset qualify done");
        rx_fifo_reset_n <= 1'b0;
        repeat (7) @(posedge clock);
        push(2, 1'b0);
        stat_is(0, 1'b1);
        rx_fifo_reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check(32'(rx_fifo_empty_flag), 32'h1);
        @(posedge clock);
        push(1, 1'b1);
        stat_is(1, 1'b0);
        drain();
        $display("test held reset done");
        axi_wr(CTRL, 32'h0);
        push(2, 1'b0);
        stat_is(0, 1'b0);
        axi_wr(CTRL, 32'h1);
        $display("test accept disable done");
        @(posedge clock);
        rx_output_enable <= 1'b1;
        code_violation_in <= 1'b1;
        @(posedge clock);
        #1 check({code_violation_oe, code_violation_flag}, 2'h3);
        @(posedge clock);
        rx_output_enable <= 1'b0;
        @(posedge clock);
        #1 check({code_violation_oe, code_violation_flag}, 2'h0);
        $display("test violation drive done");
        finish_test();
    end

endmodule : testbench

`default_nettype wire
